// ==== design/sai_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the serial audio link
`ifndef AUDIO_LINK_DEFINES_SVH
`define AUDIO_LINK_DEFINES_SVH

`define REG_RATE_CONFIG         8'h00
`define REG_SERIAL_INPUT_CONFIG 8'h01
`define REG_DESYNC_CONFIG       8'h05
`define REG_IRQ_STATUS          8'h10
`define REG_IRQ_CLEAR           8'h11
`define REG_IRQ_ENABLE          8'h12
`define REG_LIVE_STATUS         8'h13

`define SERIAL_INPUT_CONFIG_RST 8'h80
`define INTERP_RATIO_RST        2'h0
`define DESYNC_DETECT_RST       1'b0
`define IRQ_ENABLE_RST          3'h0

`define FMT_LSB                 0
`define FMT_MSB                 3
`define FIRST_BIT_POS           4
`define BCLK_DELAY_POS          5
`define CH1_SEL_POS             6
`define CH2_SEL_POS             7
`define INTERP_LSB              3
`define INTERP_MSB              4
`define DESYNC_EN_POS           0

`define IRQ_PAIR                0
`define IRQ_DESYNC              1
`define IRQ_RESYNC              2

`define CLOCK_PERIOD_NS         8
`define BCLK_PERIOD_NS          160
`define BCLK_HALF_CYCLES        (`BCLK_PERIOD_NS / (2 * `CLOCK_PERIOD_NS))
`define RATIO_IR0               13'd1280
`define RATIO_IR1               13'd640
`define RATIO_IR2               13'd320
`define RATIO_TOL               13'd4

`endif

// ==== design/sai_pkg.sv ====
// Types and format decoding shared by both ends of the serial audio link
package audio_link_pkg;
  typedef enum logic [1:0] {MODE_I2S, MODE_LJ, MODE_RJ} word_mode_t;
  typedef logic [3:0]  fmt_t;
  typedef logic [23:0] sample_t;

  function automatic word_mode_t word_mode(input fmt_t f);
    case (f[1:0])
      2'h0:    word_mode = MODE_I2S;
      2'h1:    word_mode = MODE_LJ;
      default: word_mode = MODE_RJ;
    endcase
  endfunction

  function automatic logic [4:0] word_width(input fmt_t f);
    case (f[3:2])
      2'h0:    word_width = 5'd24;
      2'h1:    word_width = 5'd20;
      2'h2:    word_width = 5'd18;
      default: word_width = 5'd16;
    endcase
  endfunction
endpackage

// ==== design/sai_if.sv ====
// Three-wire serial audio link between the source and the receiver
`timescale 1ns/10ps
interface audio_link_if;
  logic frame_clock_in;
  logic bit_clock_in;
  logic serial_data_in;

  modport source (
    output frame_clock_in,
    output bit_clock_in,
    output serial_data_in
  );
  modport receiver (
    input frame_clock_in,
    input bit_clock_in,
    input serial_data_in
  );
endinterface

// ==== design/serial_audio_source.sv ====
// Serial audio master that drives frame clock, bit clock and data
`timescale 1ns/10ps
`include "sai_defines.svh"
module serial_audio_source (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Serial link
  audio_link_if.source     link,
  // Format
  input  wire audio_link_pkg::fmt_t fmt,
  input  wire logic        first_bit,
  input  wire logic [1:0]  slot_sel,
  // Samples
  input  wire audio_link_pkg::sample_t left_in,
  input  wire audio_link_pkg::sample_t right_in,
  output logic             sample_take
);
  import audio_link_pkg::*;

  logic [4:0]  div_q;
  logic        bclk_q;
  logic        lr_q;
  logic        sd_q;
  logic [5:0]  j_q;
  logic        h_q;
  sample_t     left_q;
  sample_t     right_q;
  logic [5:0]  half;
  logic        fall;
  logic        wrap;
  logic        frame;
  logic [5:0]  jn;
  logic        hn;
  logic [4:0]  w;
  word_mode_t  mode;
  logic [6:0]  kd;
  logic [4:0]  pos;
  sample_t     word;

  always_comb begin
    case (slot_sel)
      2'h0:    half = 6'd16;
      2'h1:    half = 6'd24;
      default: half = 6'd32;
    endcase
    fall  = bclk_q && (div_q == 5'(`BCLK_HALF_CYCLES - 1));
    wrap  = (j_q >= half - 6'd1);
    frame = wrap && h_q;
    jn    = wrap ? 6'd0 : j_q + 6'd1;
    hn    = wrap ? ~h_q : h_q;
    w     = word_width(fmt);
    mode  = word_mode(fmt);
    case (mode)
      MODE_LJ:  kd = {1'b0, jn};
      MODE_I2S: kd = {1'b0, jn} - 7'd1;
      default:  kd = {1'b0, jn} - {1'b0, half} + {2'b00, w};
    endcase
    pos  = first_bit ? 5'(5'd24 - w + kd[4:0]) : 5'(5'd23 - kd[4:0]);
    word = frame ? left_in : (hn ? right_q : left_q);
  end

  // Bit clock made here by dividing the own clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_q  <= 5'h00;
      bclk_q <= 1'b0;
    end else if (div_q == 5'(`BCLK_HALF_CYCLES - 1)) begin
      div_q  <= 5'h00;
      bclk_q <= ~bclk_q;
    end else begin
      div_q  <= div_q + 5'h01;
    end
  end

  // Frame position, frame clock and data change on the falling bit clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      j_q         <= 6'h3f;
      h_q         <= 1'b1;
      lr_q        <= 1'b0;
      sd_q        <= 1'b0;
      left_q      <= 24'h000000;
      right_q     <= 24'h000000;
      sample_take <= 1'b0;
    end else begin
      sample_take <= fall && frame;
      if (fall) begin
        j_q  <= jn;
        h_q  <= hn;
        lr_q <= (mode == MODE_I2S) ? hn : ~hn;
        sd_q <= (kd < {2'b00, w}) ? word[pos] : 1'b0;
        if (frame) begin
          left_q  <= left_in;
          right_q <= right_in;
        end
      end
    end
  end

  assign link.bit_clock_in   = bclk_q;
  assign link.frame_clock_in = lr_q;
  assign link.serial_data_in = sd_q;
endmodule

// ==== design/serial_audio_input_receiver.sv ====
// Slave serial audio receiver with format decode, channel mapping and desync mute
//
// Contract
// - Device is slave; source makes both clocks
// - Source uses frame clock, bit clock, data
// - Format bits 3:0, bit 4 picks order
// - Reset default is I2S, MSB first
// - MSB first 32fs: I2S15, justified 16
// - MSB first 48/64fs: I2S, LJ, RJ widths
// - LSB first 32fs: I2S15, justified 16
// - LSB first 48fs codes for I2S, LJ, RJ
// - LSB first 64fs codes same as 48fs
// - Frame clock stays within N plus minus 4
// - Desync with enable mutes and freezes processing
// - Host soft-mutes, defers configuration until resync
// - Host lets volume ramps finish before desync
// - Bit 5 delays bit clock one cycle
// - Bit 6 picks source of channel 1
// - Bit 7 picks source of channel 2
// - Expected ratio follows interpolation ratio setting
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "sai_defines.svh"
module serial_audio_input_receiver (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Serial link
  audio_link_if.receiver   link,
  // PLL status
  input  wire logic        pll_locked,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Processing channels
  output audio_link_pkg::sample_t proc_ch1_data,
  output audio_link_pkg::sample_t proc_ch2_data,
  output logic             proc_valid,
  output logic             proc_freeze,
  // Interrupt
  output logic             irq
);
  import audio_link_pkg::*;

  logic [7:0]  cfg_q;
  logic [1:0]  ir_q;
  logic        den_q;
  logic [2:0]  ien_q;
  logic [2:0]  ist_q;
  logic [3:0]  bck_s;
  logic [1:0]  lr_s;
  logic [1:0]  sd_s;
  logic [1:0]  lock_s;
  logic        lr_p_q;
  logic        lr_bit_q;
  logic        lr_eff_q;
  logic [4:0]  k_q;
  sample_t     word_q;
  sample_t     sh_q;
  sample_t     left_q;
  logic [12:0] cnt_q;
  logic        fault_q;
  logic        fault_p_q;
  logic        pair_q;
  logic        bit_edge;
  logic        lsb;
  word_mode_t  mode;
  logic [4:0]  w;
  logic        lr_eff;
  logic        chg;
  logic [4:0]  kk;
  logic [4:0]  pos;
  sample_t     mask;
  sample_t     aligned;
  logic        old_left;
  logic [12:0] n_exp;
  logic        in_window;
  logic        lr_rise;
  logic        mute;
  logic [2:0]  ev;

  // Link pins only sampled, never driven
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bck_s  <= 4'h0;
      lr_s   <= 2'h0;
      sd_s   <= 2'h0;
      lock_s <= 2'h0;
    end else begin
      bck_s  <= {bck_s[2:0], link.bit_clock_in};
      lr_s   <= {lr_s[0], link.frame_clock_in};
      sd_s   <= {sd_s[0], link.serial_data_in};
      lock_s <= {lock_s[0], pll_locked};
    end
  end

  always_comb begin
    // Optional one-cycle bit clock delay
    bit_edge = cfg_q[`BCLK_DELAY_POS] ? (bck_s[2] & ~bck_s[3]) : (bck_s[1] & ~bck_s[2]);
    // Format decode, live from the register
    lsb      = cfg_q[`FIRST_BIT_POS];
    mode     = word_mode(cfg_q[`FMT_MSB:`FMT_LSB]);
    w        = word_width(cfg_q[`FMT_MSB:`FMT_LSB]);
    // I2S words start one bit after the frame clock edge
    lr_eff   = (mode == MODE_I2S) ? lr_bit_q : lr_s[1];
    chg      = lr_eff != lr_eff_q;
    kk       = chg ? 5'h00 : ((k_q == 5'h1f) ? k_q : k_q + 5'h01);
    pos      = lsb ? 5'(5'd24 - w + kk) : 5'(5'd23 - kk);
    mask     = ~(24'hffffff >> w);
    // Every word ends MSB-aligned in 24 bits
    if (mode == MODE_RJ)
      aligned = lsb ? (sh_q & mask) : 24'(sh_q << (5'd24 - w));
    else
      aligned = word_q;
    old_left = (mode == MODE_I2S) ? ~lr_eff_q : lr_eff_q;
    // Expected frame length from interpolation ratio
    case (ir_q)
      2'h0:    n_exp = `RATIO_IR0;
      2'h1:    n_exp = `RATIO_IR1;
      default: n_exp = `RATIO_IR2;
    endcase
    in_window = (cnt_q >= n_exp - `RATIO_TOL) && (cnt_q <= n_exp + `RATIO_TOL);
    lr_rise   = lr_s[1] & ~lr_p_q;
    mute      = fault_q & den_q;
    ev        = {~fault_q & fault_p_q, fault_q & ~fault_p_q, pair_q};
  end

  // Word assembly on each bit clock rising edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lr_bit_q <= 1'b0;
      lr_eff_q <= 1'b0;
      k_q      <= 5'h00;
      word_q   <= 24'h000000;
      sh_q     <= 24'h000000;
      left_q   <= 24'h000000;
      pair_q   <= 1'b0;
    end else begin
      pair_q <= 1'b0;
      if (bit_edge) begin
        lr_bit_q <= lr_s[1];
        lr_eff_q <= lr_eff;
        k_q      <= kk;
        sh_q     <= lsb ? {sd_s[1], sh_q[23:1]} : {sh_q[22:0], sd_s[1]};
        if (chg) begin
          word_q      <= 24'h000000;
          word_q[pos] <= sd_s[1];
          if (old_left)
            left_q <= aligned;
          else
            pair_q <= 1'b1;
        end else if (kk < w) begin
          word_q[pos] <= sd_s[1];
        end
      end
    end
  end

  // Channel mapping and mute to processing
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      proc_ch1_data <= 24'h000000;
      proc_ch2_data <= 24'h000000;
      proc_valid    <= 1'b0;
      proc_freeze   <= 1'b0;
    end else begin
      proc_freeze <= mute;
      proc_valid  <= bit_edge && chg && !old_left && !mute;
      if (mute) begin
        // Mute data and freeze processing on desync
        proc_ch1_data <= 24'h000000;
        proc_ch2_data <= 24'h000000;
      end else if (bit_edge && chg && !old_left) begin
        proc_ch1_data <= cfg_q[`CH1_SEL_POS] ? aligned : left_q;
        proc_ch2_data <= cfg_q[`CH2_SEL_POS] ? aligned : left_q;
      end
    end
  end

  // Core cycles per frame against the expected ratio and PLL lock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lr_p_q    <= 1'b0;
      cnt_q     <= 13'h0000;
      fault_q   <= 1'b0;
      fault_p_q <= 1'b0;
    end else begin
      lr_p_q    <= lr_s[1];
      fault_p_q <= fault_q;
      if (lr_rise)
        cnt_q <= 13'h0001;
      else if (cnt_q != 13'h1fff)
        cnt_q <= cnt_q + 13'h0001;
      if (!lock_s[1])
        fault_q <= 1'b1;
      else if (lr_rise)
        fault_q <= !in_window;
      else if (cnt_q > n_exp + `RATIO_TOL)
        fault_q <= 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= `SERIAL_INPUT_CONFIG_RST;
      ir_q  <= `INTERP_RATIO_RST;
      den_q <= `DESYNC_DETECT_RST;
      ien_q <= `IRQ_ENABLE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_RATE_CONFIG:         ir_q  <= reg_wdata[`INTERP_MSB:`INTERP_LSB];
        `REG_SERIAL_INPUT_CONFIG: cfg_q <= reg_wdata;
        `REG_DESYNC_CONFIG:       den_q <= reg_wdata[`DESYNC_EN_POS];
        `REG_IRQ_ENABLE:          ien_q <= reg_wdata[2:0];
        default:                  ;
      endcase
    end
  end

  // Sticky events; a new event wins over a clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ist_q <= 3'h0;
      irq   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `REG_IRQ_CLEAR)
        ist_q <= (ist_q & ~reg_wdata[2:0]) | ev;
      else
        ist_q <= ist_q | ev;
      irq <= |(ist_q & ien_q);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_RATE_CONFIG:         reg_rdata <= {3'h0, ir_q, 3'h0};
        `REG_SERIAL_INPUT_CONFIG: reg_rdata <= cfg_q;
        `REG_DESYNC_CONFIG:       reg_rdata <= {7'h00, den_q};
        `REG_IRQ_STATUS:          reg_rdata <= {5'h00, ist_q};
        `REG_IRQ_ENABLE:          reg_rdata <= {5'h00, ien_q};
        `REG_LIVE_STATUS:         reg_rdata <= {5'h00, mute, lock_s[1], fault_q};
        default:                  reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// ==== test/serial_audio_link_sva.sv ====
// Wire-level checks on the serial audio link
`timescale 1ns/10ps
module serial_audio_link_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Link
  input wire logic frame_clock_in,
  input wire logic bit_clock_in,
  input wire logic serial_data_in
);
  logic [9:0] since_q;
  logic       seen_q;
  logic       frame_q;

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // Cycles since the last frame clock change
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      since_q <= 10'h0;
      seen_q  <= 1'b0;
      frame_q <= 1'b0;
    end else begin
      frame_q <= frame_clock_in;
      since_q <= (frame_clock_in != frame_q) ? 10'h0 : since_q + 10'h1;
      seen_q  <= seen_q | (frame_clock_in != frame_q);
    end
  end

  a_frame_on_fall: assert property ($changed(frame_clock_in) |-> $fell(bit_clock_in))
    else $error("Frame clock moved off a falling bit clock");
  a_data_on_fall: assert property ($changed(serial_data_in) |-> $fell(bit_clock_in))
    else $error("Data moved off a falling bit clock");
  a_bclk_high_time: assert property ($rose(bit_clock_in) |=> bit_clock_in[*8])
    else $error("Bit clock high phase too short");
  a_bclk_low_time: assert property ($fell(bit_clock_in) |=> !bit_clock_in[*8])
    else $error("Bit clock low phase too short");
  a_bclk_fall_ten: assert property ($rose(bit_clock_in) |-> ##10 $fell(bit_clock_in))
    else $error("Bit clock high phase not ten cycles");
  a_bclk_rise_ten: assert property ($fell(bit_clock_in) |-> ##10 $rose(bit_clock_in))
    else $error("Bit clock low phase not ten cycles");
  a_data_held_high: assert property ($rose(bit_clock_in) |=> $stable(serial_data_in)[*8])
    else $error("Data changed while bit clock high");
  a_frame_half_len: assert property ($changed(frame_clock_in) && seen_q |-> since_q inside {319, 479, 639})
    else $error("Frame clock half is not 16, 24 or 32 bits");
endmodule

// ==== test/serial_audio_input_receiver_bench.sv ====
// Self-checking bench: source and receiver joined over the serial link
`timescale 1ns/10ps
`include "sai_defines.svh"
module serial_audio_input_receiver_bench;
  import audio_link_pkg::*;
  logic        clock, rstn, pll_locked, reg_wr, reg_rd, first_bit, proc_valid, proc_freeze, irq;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  slot_sel;
  fmt_t        fmt;
  sample_t     ch1, ch2, left_in, right_in;
  int          num_errors, samples_checked;

  audio_link_if link();
  serial_audio_source serial_audio_source_inst (.clock, .rstn, .link(link.source), .fmt, .first_bit, .slot_sel,
    .left_in, .right_in, .sample_take());
  serial_audio_input_receiver serial_audio_input_receiver_inst (.clock, .rstn, .link(link.receiver), .pll_locked,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .proc_ch1_data(ch1), .proc_ch2_data(ch2), .proc_valid,
    .proc_freeze, .irq);
  serial_audio_link_sva serial_audio_link_sva_inst (.clock, .rstn, .frame_clock_in(link.frame_clock_in),
    .bit_clock_in(link.bit_clock_in), .serial_data_in(link.serial_data_in));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Waits for proc_valid (0), freeze high (1) or freeze low (2)
  task automatic wait_for(input int w, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n > lim) begin
        num_errors++;
        $display("CHECK FAILED at %0t: wait %0d timed out", $time, w);
        final_report();
      end
    end while ((w == 0 ? proc_valid : w == 1 ? proc_freeze : !proc_freeze) !== 1'b1);
  endtask

  task automatic restart(input fmt_t f, input logic fb, input logic [1:0] ss);
    @(posedge clock);
    rstn <= 1'b0;
    fmt <= f;
    first_bit <= fb;
    slot_sel <= ss;
    pll_locked <= 1'b1;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    check(reg_rdata, exp, what);
  endtask

  task automatic test_reset_values();
    restart(4'h0, 1'b0, 2'h2);
    rd(`REG_SERIAL_INPUT_CONFIG, 8'h80, "config reset");
    rd(`REG_DESYNC_CONFIG, 8'h00, "desync enable reset");
    rd(`REG_RATE_CONFIG, 8'h00, "ratio reset");
    wr(`REG_SERIAL_INPUT_CONFIG, 8'h5a);
    rd(`REG_SERIAL_INPUT_CONFIG, 8'h5a, "config readback");
    rd(8'h7f, 8'h00, "unmapped read");
    $display("Test reset values done");
  endtask

  // Entries: format, first bit, slot size, word width
  task automatic test_formats();
    logic [11:0] tbl [19];
    logic [23:0] m;
    tbl = '{{4'h0, 1'b0, 2'h2, 5'd24}, {4'h1, 1'b0, 2'h1, 5'd24}, {4'h2, 1'b0, 2'h2, 5'd24},
            {4'h6, 1'b0, 2'h2, 5'd20}, {4'ha, 1'b0, 2'h1, 5'd18}, {4'he, 1'b0, 2'h2, 5'd16},
            {4'h4, 1'b1, 2'h1, 5'd20}, {4'h8, 1'b1, 2'h1, 5'd18}, {4'hc, 1'b1, 2'h1, 5'd16},
            {4'h0, 1'b1, 2'h2, 5'd24}, {4'h5, 1'b1, 2'h2, 5'd20}, {4'h9, 1'b1, 2'h2, 5'd18},
            {4'hd, 1'b1, 2'h1, 5'd16}, {4'h1, 1'b1, 2'h1, 5'd24}, {4'h2, 1'b1, 2'h2, 5'd24},
            {4'he, 1'b1, 2'h1, 5'd16}, {4'h0, 1'b0, 2'h0, 5'd15}, {4'h1, 1'b0, 2'h0, 5'd16},
            {4'he, 1'b1, 2'h0, 5'd16}};
    foreach (tbl[i]) begin
      restart(tbl[i][11:8], tbl[i][7], tbl[i][6:5]);
      wr(`REG_SERIAL_INPUT_CONFIG, {i[1:0], i[2], tbl[i][7], tbl[i][11:8]});
      m = 24'hffffff << (24 - tbl[i][4:0]);
      wait_for(0, 4000);
      wait_for(0, 4000);
      check(ch1, (i[0] ? right_in : left_in) & m, "channel 1 word");
      check(ch2, (i[1] ? right_in : left_in) & m, "channel 2 word");
    end
    $display("Test formats done");
  endtask

  task automatic test_desync();
    restart(4'h0, 1'b0, 2'h2);
    wr(`REG_DESYNC_CONFIG, 8'h01);
    wr(`REG_IRQ_ENABLE, 8'h02);
    wait_for(0, 4000);
    wait_for(0, 4000);
    wr(`REG_IRQ_CLEAR, 8'h07);
    repeat (2) @(negedge clock);
    check(irq, 1'b0, "irq after clear");
    @(posedge clock);
    pll_locked <= 1'b0;
    wait_for(1, 10);
    check(ch1, 24'h0, "muted data");
    repeat (4) @(negedge clock);
    check(irq, 1'b1, "irq on desync");
    rd(`REG_LIVE_STATUS, 8'h05, "live status in desync");
    @(posedge clock);
    pll_locked <= 1'b1;
    wait_for(2, 4000);
    wr(`REG_IRQ_ENABLE, 8'h00);
    repeat (2) @(negedge clock);
    check(irq, 1'b0, "irq masked");
    wr(`REG_IRQ_CLEAR, 8'h02);
    wr(`REG_IRQ_ENABLE, 8'h02);
    repeat (2) @(negedge clock);
    check(irq, 1'b0, "irq cleared");
    wr(`REG_RATE_CONFIG, 8'h08);
    wait_for(1, 4000);
    check(proc_freeze, 1'b1, "ratio mismatch freeze");
    wr(`REG_RATE_CONFIG, 8'h00);
    wait_for(2, 4000);
    wr(`REG_DESYNC_CONFIG, 8'h00);
    pll_locked <= 1'b0;
    repeat (10) @(negedge clock);
    check(proc_freeze, 1'b0, "no freeze when disabled");
    $display("Test desync done");
  endtask

  initial begin
    rstn = 1'b0;
    pll_locked = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fmt = 4'h0;
    first_bit = 1'b0;
    slot_sel = 2'h2;
    left_in = 24'hc3a55a;
    right_in = 24'h5a3cc7;
    num_errors = 0;
    samples_checked = 0;
    test_reset_values();
    test_formats();
    test_desync();
    final_report();
  end
endmodule
